/* rtl/rrs_pkg.sv */
// rrs_pkg: constants and carrier types for the rotate-right / power-down executor.
// assumes a core that hands over one 16-bit instruction word per instruction cycle.
package rrs_pkg;

    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    localparam logic [5:0]  ROT_OPC_HI      = 6'h10;     // upper six bits 0100 00
    localparam logic [15:0] SLEEP_OPCODE    = 16'h0003;  // power-down word
    localparam int          OPC_HI_POS      = 10;        // lsb of the six-bit opcode field
    localparam int          DEST_POS        = 9;
    localparam int          BANK_SEL_POS    = 8;
    localparam logic [7:0]  INDEXED_MAX     = 8'h5F;     // highest offset for indexed mode

    // ------------------------------------------------------------
    // reset values and phase counts
    // ------------------------------------------------------------
    localparam logic [7:0]  ACC_RESET       = 8'h00;
    localparam logic        PD_FLAG_RESET   = 1'b1;
    localparam logic        TO_FLAG_RESET   = 1'b1;
    localparam logic [1:0]  PHASE_COUNT_MAX = 2'h3;      // four phases per instruction

    typedef enum logic [1:0] {
        PH_DECODE,
        PH_READ,
        PH_PROCESS,
        PH_WRITE
    } rrs_phase_type;

    // data-memory access request
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [3:0] bank;
        logic [7:0] addr;
        logic       access_bank;
        logic       indexed;
        logic [7:0] wdata;
    } rrs_mem_req_type;

    // whole block state
    typedef struct packed {
        rrs_phase_type   phase;
        logic [15:0]     instr;
        logic [7:0]      operand;
        logic [7:0]      result;
        logic [7:0]      acc;
        logic            neg_flag;
        logic            zero_flag;
        logic            pd_flag;
        logic            to_flag;
        logic            wdt_clr;
        logic            sleeping;
        logic            busy;
        rrs_mem_req_type mem;
    } rrs_state_type;

endpackage

/* rtl/rrs_exec.sv */
// rrs_exec: executes the plain rotate-right and the power-down instruction.
// assumes the fetch unit offers one instruction word with a valid strobe while
// ready is high, and data memory answers a read in the phase after the request.
//
// Operation
// - rotate right, bit zero wraps to seven
// - decode 0100 00da ffffffff as rotate
// - rotate updates only negative and zero flags
// - d=0 writes accumulator, d=1 writes file
// - a=0 access bank, a=1 bank pointer
// - a=0, extended set, f<=5F: indexed addressing
// - power-down clears watchdog and its postscaler
// - power-down clears power-down flag
// - power-down sets time-out flag
// - after power-down, halt until wake-up
// - watchdog wake-up clears time-out flag
`timescale 1ns/1ps

module rrs_exec
    import rrs_pkg::*;
(
    input  wire logic        mclk_in,
    input  wire logic        reset_n_in,
    input  wire logic [15:0] instr_in,
    input  wire logic        instr_valid_in,
    input  wire logic [3:0]  bank_pointer_in,
    input  wire logic        ext_set_en_in,
    input  wire logic [7:0]  mem_rdata_in,
    input  wire logic        neg_flag_in,
    input  wire logic        zero_flag_in,
    input  wire logic        wake_in,
    input  wire logic        wake_wdt_in,
    output logic             instr_ready_out,
    output rrs_mem_req_type  mem_req_out,
    output logic [7:0]       acc_out,
    output logic             neg_flag_out,
    output logic             zero_flag_out,
    output logic             flags_we_out,
    output logic             power_down_flag_out,
    output logic             timeout_flag_out,
    output logic             watchdog_clear_out,
    output logic             osc_halt_out,
    output logic             done_out
);

    // ------------------------------------------------------------
    // state registers
    // ------------------------------------------------------------
    rrs_state_type st_ff;
    rrs_state_type nxt_st;
    logic          wake_meta_ff;
    logic          wake_sync_ff;
    logic          wdt_meta_ff;
    logic          wdt_sync_ff;

    logic is_rot;
    logic is_sleep;
    logic flags_we;
    logic done;

    // wake pins come from the asleep domain, so synchronise before use
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            wake_meta_ff <= 1'b0;
            wake_sync_ff <= 1'b0;
            wdt_meta_ff  <= 1'b0;
            wdt_sync_ff  <= 1'b0;
        end else begin
            wake_meta_ff <= wake_in;
            wake_sync_ff <= wake_meta_ff;
            wdt_meta_ff  <= wake_wdt_in;
            wdt_sync_ff  <= wdt_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // decode of the held instruction word
    // ------------------------------------------------------------
    assign is_rot   = (st_ff.instr[15:OPC_HI_POS] == ROT_OPC_HI);
    assign is_sleep = (st_ff.instr == SLEEP_OPCODE);

    // ------------------------------------------------------------
    // phase sequencer and execution
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.wdt_clr = 1'b0;
        flags_we = 1'b0;
        done = 1'b0;
        nxt_st.mem.rd = 1'b0;
        nxt_st.mem.wr = 1'b0;
        if (st_ff.sleeping) begin
            // oscillator stopped: nothing executes until a wake event
            if (wake_sync_ff || wdt_sync_ff) begin
                nxt_st.sleeping = 1'b0;
                if (wdt_sync_ff) begin
                    nxt_st.to_flag = 1'b0;
                end
            end
        end else begin
            unique case (st_ff.phase)
                PH_DECODE: begin
                    if (instr_valid_in) begin
                        nxt_st.instr = instr_in;
                        nxt_st.busy  = 1'b1;
                        nxt_st.phase = PH_READ;
                    end
                end
                PH_READ: begin
                    // sleep performs no read in this phase
                    if (st_ff.instr[15:OPC_HI_POS] == ROT_OPC_HI) begin
                        nxt_st.mem.rd          = 1'b1;
                        nxt_st.mem.addr        = st_ff.instr[7:0];
                        nxt_st.mem.access_bank = ~st_ff.instr[BANK_SEL_POS];
                        nxt_st.mem.bank        = st_ff.instr[BANK_SEL_POS] ?
                                                 bank_pointer_in : 4'h0;
                        nxt_st.mem.indexed     = ~st_ff.instr[BANK_SEL_POS] && ext_set_en_in
                                                 && (st_ff.instr[7:0] <= INDEXED_MAX);
                    end
                    nxt_st.phase = PH_PROCESS;
                end
                PH_PROCESS: begin
                    if (is_rot) begin
                        nxt_st.operand   = mem_rdata_in;
                        nxt_st.result    = {mem_rdata_in[0], mem_rdata_in[7:1]};
                        nxt_st.neg_flag  = mem_rdata_in[0];
                        nxt_st.zero_flag = (mem_rdata_in == 8'h00);
                    end else if (is_sleep) begin
                        nxt_st.wdt_clr = 1'b1;
                        nxt_st.pd_flag = 1'b0;
                        nxt_st.to_flag = 1'b1;
                    end
                    nxt_st.phase = PH_WRITE;
                end
                PH_WRITE: begin
                    if (is_rot) begin
                        flags_we = 1'b1;
                        if (st_ff.instr[DEST_POS]) begin
                            nxt_st.mem.wr    = 1'b1;
                            nxt_st.mem.wdata = st_ff.result;
                        end else begin
                            nxt_st.acc = st_ff.result;
                        end
                    end else if (is_sleep) begin
                        nxt_st.sleeping = 1'b1;
                    end
                    done = 1'b1;
                    nxt_st.busy  = 1'b0;
                    nxt_st.phase = PH_DECODE;
                end
            endcase
        end
    end

    // one register for the whole state
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_ff <= '{phase: PH_DECODE, instr: 16'h0000, operand: 8'h00, result: 8'h00,
                       acc: ACC_RESET, neg_flag: 1'b0, zero_flag: 1'b0,
                       pd_flag: PD_FLAG_RESET, to_flag: TO_FLAG_RESET, wdt_clr: 1'b0,
                       sleeping: 1'b0, busy: 1'b0,
                       mem: '{rd: 1'b0, wr: 1'b0, bank: 4'h0, addr: 8'h00,
                              access_bank: 1'b0, indexed: 1'b0, wdata: 8'h00}};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // untouched arithmetic flags pass through; only n and z ever change here
    assign neg_flag_out        = flags_we ? st_ff.neg_flag  : neg_flag_in;
    assign zero_flag_out       = flags_we ? st_ff.zero_flag : zero_flag_in;
    assign flags_we_out        = flags_we;
    assign instr_ready_out     = (st_ff.phase == PH_DECODE) && !st_ff.sleeping;
    assign mem_req_out         = st_ff.mem;
    assign acc_out             = st_ff.acc;
    assign power_down_flag_out = st_ff.pd_flag;
    assign timeout_flag_out    = st_ff.to_flag;
    assign watchdog_clear_out  = st_ff.wdt_clr;
    assign osc_halt_out        = st_ff.sleeping;
    assign done_out            = done;

endmodule

/* test/rrs_exec_properties.sv */
// rrs_exec_properties: port-level timing checks for the executor.
// assumes the single instruction clock and the async active-low reset.
`timescale 1ns/1ps
module rrs_exec_properties
    import rrs_pkg::*;
(
    input wire logic            mclk_in,
    input wire logic            reset_n_in,
    input wire logic [15:0]     instr_in,
    input wire logic            instr_valid_in,
    input wire logic            ext_set_en_in,
    input wire logic [7:0]      mem_rdata_in,
    input wire logic            instr_ready_out,
    input wire rrs_mem_req_type mem_req_out,
    input wire logic            flags_we_out,
    input wire logic            neg_flag_out,
    input wire logic            zero_flag_out,
    input wire logic            power_down_flag_out,
    input wire logic            timeout_flag_out,
    input wire logic            watchdog_clear_out,
    input wire logic            osc_halt_out,
    input wire logic            done_out
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // ------------------------------------------------------------
    // take qualifiers
    // ------------------------------------------------------------
    logic take;
    logic rot;
    assign take = instr_valid_in && instr_ready_out;
    assign rot  = take && (instr_in[15:10] == ROT_OPC_HI);
    // one word finishes exactly in its fourth phase
    AST_DONE: assert property (take |-> ##3 done_out)
        else $error("done not three cycles after take");
    AST_BUSY: assert property (take |=> !instr_ready_out [*3])
        else $error("ready during a running instruction");
    // the read request is registered out of the read phase, so it is seen two edges on
    AST_READ: assert property (rot |-> ##2 mem_req_out.rd
        && mem_req_out.addr == $past(instr_in[7:0], 2))
        else $error("rotate read request wrong");
    AST_BANK: assert property (rot |-> ##2 mem_req_out.access_bank == !$past(instr_in[8], 2))
        else $error("bank choice wrong");
    AST_INDEX: assert property (rot |-> ##2 mem_req_out.indexed == (!$past(instr_in[8], 2)
        && $past(ext_set_en_in, 2) && $past(instr_in[7:0], 2) <= INDEXED_MAX))
        else $error("indexed mode flag wrong");
    AST_FLAGS: assert property (rot |-> ##3 flags_we_out
        && neg_flag_out == $past(mem_rdata_in[0])
        && zero_flag_out == ($past(mem_rdata_in) == 8'h00))
        else $error("rotate flags wrong");
    AST_WRITE: assert property (rot && instr_in[9] |-> ##4 mem_req_out.wr
        && mem_req_out.wdata == {$past(mem_rdata_in[0], 2), $past(mem_rdata_in[7:1], 2)})
        else $error("rotate write back wrong");
    AST_SLEEP: assert property (take && instr_in == SLEEP_OPCODE |-> ##3 watchdog_clear_out
        && !power_down_flag_out && timeout_flag_out ##1 osc_halt_out)
        else $error("power-down effects wrong");
    AST_HALT: assert property (osc_halt_out |-> !instr_ready_out)
        else $error("instruction taken while halted");
    C_ROT: cover property (rot ##4 mem_req_out.wr);
    C_ACC: cover property (rot && !instr_in[9]);
    C_SLEEP: cover property (osc_halt_out ##1 !osc_halt_out);
endmodule

bind rrs_exec rrs_exec_properties rrs_exec_properties_i (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .instr_in(instr_in), .instr_valid_in(instr_valid_in),
    .ext_set_en_in(ext_set_en_in), .mem_rdata_in(mem_rdata_in),
    .instr_ready_out(instr_ready_out), .mem_req_out(mem_req_out),
    .flags_we_out(flags_we_out), .neg_flag_out(neg_flag_out),
    .zero_flag_out(zero_flag_out), .power_down_flag_out(power_down_flag_out),
    .timeout_flag_out(timeout_flag_out), .watchdog_clear_out(watchdog_clear_out),
    .osc_halt_out(osc_halt_out), .done_out(done_out));

/* test/rrs_exec_bench.sv */
// rrs_exec_bench: directed tests of rotate and power-down words.
// assumes rrs_exec with its checker bound; bench plays fetch unit and memory.
`timescale 1ns/1ps
module rrs_exec_bench import rrs_pkg::*;;
    logic mclk_in = 0, reset_n_in = 0, instr_valid_in = 0, ext_set_en_in = 0;
    logic wake_in = 0, wake_wdt_in = 0, neg_flag_in = 0, zero_flag_in = 0;
    logic [15:0] instr_in = 16'h0000;
    logic [3:0]  bank_pointer_in = 4'h5;
    logic [7:0]  mem_rdata_in = 8'h00, acc_out;
    logic instr_ready_out, neg_flag_out, zero_flag_out, flags_we_out, done_out;
    logic power_down_flag_out, timeout_flag_out, watchdog_clear_out, osc_halt_out;
    logic [6:0]  fl;
    rrs_mem_req_type mem_req_out, req, nxt;
    int fail_count = 0, compares = 0, cyc = 0, n;
    rrs_exec rrs_exec_i (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .bank_pointer_in(bank_pointer_in),
        .ext_set_en_in(ext_set_en_in), .mem_rdata_in(mem_rdata_in),
        .neg_flag_in(neg_flag_in), .zero_flag_in(zero_flag_in), .wake_in(wake_in),
        .wake_wdt_in(wake_wdt_in), .instr_ready_out(instr_ready_out),
        .mem_req_out(mem_req_out), .acc_out(acc_out), .neg_flag_out(neg_flag_out),
        .zero_flag_out(zero_flag_out), .flags_we_out(flags_we_out),
        .power_down_flag_out(power_down_flag_out), .timeout_flag_out(timeout_flag_out),
        .watchdog_clear_out(watchdog_clear_out), .osc_halt_out(osc_halt_out),
        .done_out(done_out));
    always #5 mclk_in = ~mclk_in;
    // hang guard: a few dozen cycles are plenty for these tests
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            fail_count++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [15:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // offer one word; keep read request, write-phase outputs and the cycle after
    task automatic run(input logic [15:0] w, input logic [7:0] rdata);
        @(posedge mclk_in);
        instr_in       <= w;
        instr_valid_in <= 1'b1;
        mem_rdata_in   <= rdata;
        @(posedge mclk_in);
        instr_valid_in <= 1'b0;
        // the read request is registered out of the read phase, one edge after the take
        @(posedge mclk_in);
        #1 req = mem_req_out;
        n = 0;
        while (done_out !== 1'b1 && n < 8) begin
            @(posedge mclk_in);
            #1 n++;
        end
        fl = {flags_we_out, neg_flag_out, zero_flag_out, done_out,
              watchdog_clear_out, power_down_flag_out, timeout_flag_out};
        @(posedge mclk_in);
        #1 nxt = mem_req_out;
    endtask
    task automatic report_and_stop();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (5) @(posedge mclk_in);
        reset_n_in <= 1'b1;
        #1 check("reset flags", {power_down_flag_out, timeout_flag_out, acc_out}, 16'h03_00);
        run({6'h10, 2'b11, 8'h2A}, 8'hE5);
        check("read req", {req.rd, req.bank, req.addr, req.access_bank}, 16'h2A54);
        check("flags", fl, 7'h6B);
        check("write back", {nxt.wr, nxt.wdata}, 16'h01_F2);
        $display("test rotate to file done");
        ext_set_en_in <= 1'b1;
        run({6'h10, 2'b00, 8'h5F}, 8'h01);
        check("indexed", {req.indexed, req.access_bank, req.bank}, 16'h0030);
        check("flags", fl, 7'h6B);
        check("acc", {nxt.wr, acc_out}, 16'h0080);
        run({6'h10, 2'b00, 8'h60}, 8'h00);
        check("not indexed", req.indexed, 16'h0000);
        check("zero", fl, 7'h5B);
        check("acc", acc_out, 16'h0000);
        $display("test rotate to accumulator done");
        run(16'h0004, 8'hFF);
        check("no-op", {fl, osc_halt_out}, 16'h0016);
        run(SLEEP_OPCODE, 8'h00);
        check("sleep", fl, 7'h0D);
        check("halt", {osc_halt_out, instr_ready_out}, 16'h0002);
        wake_in     <= 1'b1;
        wake_wdt_in <= 1'b1;
        n = 0;
        while (osc_halt_out !== 1'b0 && n < 10) begin
            @(posedge mclk_in);
            #1 n++;
        end
        check("wake", {osc_halt_out, timeout_flag_out}, 16'h0000);
        wake_in     <= 1'b0;
        wake_wdt_in <= 1'b0;
        $display("test power-down done");
        report_and_stop();
    end
endmodule
